// ===== lrs_pkg.sv
`default_nettype none
package lrs_pkg;

  // apb register byte offsets
  localparam logic [11:0] REG_COMMAND = 12'h000;
  localparam logic [11:0] REG_WORK = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_COUNTER = 12'h00C;
  localparam logic [11:0] REG_STACK_TOP = 12'h010;
  localparam logic [2:0] RAM_WINDOW_SEL = 3'h1;
  localparam int RAM_WINDOW_HI = 11;
  localparam int RAM_WINDOW_LO = 9;
  localparam int RAM_INDEX_HI = 8;
  localparam int RAM_INDEX_LO = 2;

  // command word fields
  localparam int CMD_OP_HI = 4;
  localparam int CMD_OP_LO = 0;
  localparam int CMD_ADDR_HI = 14;
  localparam int CMD_ADDR_LO = 8;
  localparam int CMD_IMM_HI = 23;
  localparam int CMD_IMM_LO = 16;
  localparam int CMD_TARGET_HI = 26;
  localparam int CMD_TARGET_LO = 16;

  // status word fields
  localparam int ST_CARRY = 0;
  localparam int ST_HALF_BORROW = 1;
  localparam int ST_NULL_RESULT = 2;
  localparam int ST_SIGNED_EXCESS = 3;
  localparam int ST_SIGNED_BORROW = 4;
  localparam int ST_CHAINED_ZERO = 5;
  localparam int ST_GIE = 6;
  localparam int ST_BUSY = 8;
  localparam int ST_SKIPPED = 9;
  localparam int ST_DEPTH_LO = 12;
  localparam int ST_DEPTH_HI = 14;

  // sizes and fixed values
  localparam int RAM_WORDS = 128;
  localparam int STACK_LEVELS = 4;
  localparam int PC_W = 11;
  localparam logic [10:0] IRQ_VECTOR = 11'h004;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic [4:0] {
    OP_IDLE_NOP = 5'h00,
    OP_UNION_W_RAM = 5'h01,
    OP_UNION_W_IMM = 5'h02,
    OP_UNION_RAM = 5'h03,
    OP_POP_RESUME = 5'h04,
    OP_POP_RESUME_LIT = 5'h05,
    OP_IRQ_EXIT = 5'h06,
    OP_ROT_L_MEM = 5'h07,
    OP_ROT_L_W = 5'h08,
    OP_ROT_LC_MEM = 5'h09,
    OP_ROT_LC_W = 5'h0A,
    OP_ROT_R_MEM = 5'h0B,
    OP_ROT_R_W = 5'h0C,
    OP_ROT_RC_MEM = 5'h0D,
    OP_ROT_RC_W = 5'h0E,
    OP_SUBB_W_RAM = 5'h0F,
    OP_SUBB_W_IMM = 5'h10,
    OP_SUBB_RAM = 5'h11,
    OP_DEC_SKIP_MEM = 5'h12,
    OP_DEC_SKIP_W = 5'h13,
    OP_PUSH_CALL = 5'h14
  } lrs_op_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_DUMMY = 2'b11,
    S_VECT = 2'b10
  } lrs_state_e;

  typedef struct packed {
    logic chained_zero;
    logic signed_borrow;
    logic signed_excess;
    logic null_result;
    logic half_borrow;
    logic carry;
  } lrs_flags_s;

  typedef struct packed {
    lrs_op_e op;
    logic [6:0] addr;
    logic [7:0] imm;
    logic [10:0] target;
  } lrs_cmd_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lrs_apb_out_s;

endpackage
`default_nettype wire

// ===== lrs_core.sv
// Register access over APB and the register addresses are this design's own decisions.
`default_nettype none
module lrs_core
  import lrs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt side
  input wire logic irq_request,
  output logic global_irq_enable,
  output logic irq_vector_taken
);

  typedef struct packed {
    lrs_state_e st;
    lrs_apb_out_s apb;
    lrs_cmd_s cmd;
    logic [7:0] work;
    lrs_flags_s flags;
    logic gie;
    logic [10:0] pc;
    logic [1:0] sp;
    logic [2:0] depth;
    logic [STACK_LEVELS-1:0][10:0] stack;
    logic [RAM_WORDS-1:0][7:0] ram;
    logic skipped;
    logic vect_pulse;
    logic irq_meta;
    logic irq_sync;
  } lrs_core_s;

  lrs_core_s q;
  lrs_core_s next_q;

  logic access;
  logic in_ram;
  logic [6:0] ram_index;
  logic [7:0] operand;
  logic [7:0] sub_rhs;
  logic [8:0] diff;
  logic [4:0] half_diff;
  logic [7:0] union_w;
  logic [7:0] dec_val;
  logic [10:0] pc_next_seq;
  logic [1:0] sp_dec;
  logic [1:0] sp_inc;
  logic [31:0] status_word;

  // one take per transfer; a standing ready blocks a retake
  assign access = psel & penable & ~q.apb.pready;
  // byte i of ram sits at word i of the window
  assign in_ram = paddr[RAM_WINDOW_HI:RAM_WINDOW_LO] == RAM_WINDOW_SEL;
  assign ram_index = paddr[RAM_INDEX_HI:RAM_INDEX_LO];
  assign operand = q.ram[q.cmd.addr];
  assign sub_rhs = (q.cmd.op == OP_SUBB_W_IMM) ? q.cmd.imm : operand;
  // borrow-in is the inverted carry
  assign diff = {1'b0, q.work} - {1'b0, sub_rhs}
              - {8'h00, ~q.flags.carry};
  // low-nibble borrow feeds the half-borrow flag
  assign half_diff = {1'b0, q.work[3:0]} - {1'b0, sub_rhs[3:0]}
                   - {4'h0, ~q.flags.carry};
  assign union_w = q.work | ((q.cmd.op == OP_UNION_W_IMM) ?
                   q.cmd.imm : operand);
  // 00 wraps to FF; no flag is touched
  assign dec_val = operand - BYTE_ONE;
  assign pc_next_seq = q.pc + 11'h001;
  // pointer wraps, so an overflow overwrites the oldest entry
  assign sp_dec = q.sp - 2'h1;
  assign sp_inc = q.sp + 2'h1;

  always_comb
  begin
    status_word = '0;
    status_word[ST_CARRY] = q.flags.carry;
    status_word[ST_HALF_BORROW] = q.flags.half_borrow;
    status_word[ST_NULL_RESULT] = q.flags.null_result;
    status_word[ST_SIGNED_EXCESS] = q.flags.signed_excess;
    status_word[ST_SIGNED_BORROW] = q.flags.signed_borrow;
    status_word[ST_CHAINED_ZERO] = q.flags.chained_zero;
    status_word[ST_GIE] = q.gie;
    status_word[ST_BUSY] = q.st != S_IDLE;
    status_word[ST_SKIPPED] = q.skipped;
    status_word[ST_DEPTH_HI:ST_DEPTH_LO] = q.depth;
  end

  always_comb
  begin
    next_q = q;
    // request is asynchronous: two flops before any use
    next_q.irq_meta = irq_request;
    next_q.irq_sync = q.irq_meta;
    // vector strobe lasts one cycle
    next_q.vect_pulse = 1'b0;
    // ready and error stand for a single cycle
    if (q.apb.pready)
    begin
      next_q.apb.pready = 1'b0;
      next_q.apb.pslverr = 1'b0;
    end
    case (q.st)
      // bus is served only while idle
      S_IDLE:
      begin
        if (access)
        begin
          next_q.apb.pready = 1'b1;
          next_q.apb.pslverr = 1'b0;
          if (in_ram)
          begin
            if (pwrite)
              next_q.ram[ram_index] = pwdata[7:0];
            else
              next_q.apb.prdata = {24'h000000, q.ram[ram_index]};
          end
          else
          begin
            case (paddr)
              REG_COMMAND:
              begin
                if (pwrite)
                begin
                  // answer held back until execution ends
                  next_q.apb.pready = 1'b0;
                  next_q.cmd.op = lrs_op_e'(pwdata[CMD_OP_HI:CMD_OP_LO]);
                  next_q.cmd.addr = pwdata[CMD_ADDR_HI:CMD_ADDR_LO];
                  next_q.cmd.imm = pwdata[CMD_IMM_HI:CMD_IMM_LO];
                  next_q.cmd.target = pwdata[CMD_TARGET_HI:CMD_TARGET_LO];
                  next_q.st = S_EXEC;
                end
                else
                  next_q.apb.prdata = {27'h0000000, q.cmd.op};
              end
              REG_WORK:
              begin
                if (pwrite)
                  next_q.work = pwdata[7:0];
                else
                  next_q.apb.prdata = {24'h000000, q.work};
              end
              REG_STATUS:
              begin
                if (pwrite)
                begin
                  next_q.flags.carry = pwdata[ST_CARRY];
                  next_q.flags.half_borrow = pwdata[ST_HALF_BORROW];
                  next_q.flags.null_result = pwdata[ST_NULL_RESULT];
                  next_q.flags.signed_excess = pwdata[ST_SIGNED_EXCESS];
                  next_q.flags.signed_borrow = pwdata[ST_SIGNED_BORROW];
                  next_q.flags.chained_zero = pwdata[ST_CHAINED_ZERO];
                  next_q.gie = pwdata[ST_GIE];
                end
                else
                  next_q.apb.prdata = status_word;
              end
              REG_COUNTER:
              begin
                if (pwrite)
                  next_q.pc = pwdata[PC_W-1:0];
                else
                  next_q.apb.prdata = {21'h000000, q.pc};
              end
              REG_STACK_TOP:
              begin
                if (pwrite)
                begin
                  // read-only: refused, and no stale data shown
                  next_q.apb.pslverr = 1'b1;
                  next_q.apb.prdata = '0;
                end
                else
                  next_q.apb.prdata = {21'h000000, q.stack[sp_dec]};
              end
              // unmapped: error, no effect
              default:
              begin
                next_q.apb.pslverr = 1'b1;
                next_q.apb.prdata = '0;
              end
            endcase
          end
        end
      end

      S_EXEC:
      begin
        next_q.st = S_IDLE;
        next_q.apb.pready = 1'b1;
        next_q.skipped = 1'b0;
        // the counter moves on by one unless a pop, call or skip below reloads it
        next_q.pc = pc_next_seq;
        case (q.cmd.op)
          OP_UNION_W_RAM, OP_UNION_W_IMM:
          begin
            next_q.work = union_w;
            next_q.flags.null_result = union_w == BYTE_ZERO;
          end
          OP_UNION_RAM:
          begin
            next_q.ram[q.cmd.addr] = q.work | operand;
            next_q.flags.null_result =
              (q.work | operand) == BYTE_ZERO;
          end
          // pop; an empty stack wraps to its last entry
          OP_POP_RESUME, OP_POP_RESUME_LIT, OP_IRQ_EXIT:
          begin
            next_q.pc = q.stack[sp_dec];
            next_q.sp = sp_dec;
            if (q.depth != 3'h0)
              next_q.depth = q.depth - 3'h1;
            if (q.cmd.op == OP_POP_RESUME_LIT)
              next_q.work = q.cmd.imm;
            if (q.cmd.op == OP_IRQ_EXIT)
            begin
              next_q.gie = 1'b1;
              if (q.irq_sync)
              begin
                // hold answer; vector before resuming
                next_q.st = S_VECT;
                next_q.apb.pready = 1'b0;
              end
            end
          end
          // memory forms write back; register forms leave ram alone
          OP_ROT_L_MEM:
            next_q.ram[q.cmd.addr] = {operand[6:0], operand[7]};
          OP_ROT_L_W:
            next_q.work = {operand[6:0], operand[7]};
          OP_ROT_LC_MEM, OP_ROT_LC_W:
          begin
            if (q.cmd.op == OP_ROT_LC_MEM)
              next_q.ram[q.cmd.addr] = {operand[6:0], q.flags.carry};
            else
              next_q.work = {operand[6:0], q.flags.carry};
            next_q.flags.carry = operand[7];
          end
          OP_ROT_R_MEM:
            next_q.ram[q.cmd.addr] = {operand[0], operand[7:1]};
          OP_ROT_R_W:
            next_q.work = {operand[0], operand[7:1]};
          OP_ROT_RC_MEM, OP_ROT_RC_W:
          begin
            if (q.cmd.op == OP_ROT_RC_MEM)
              next_q.ram[q.cmd.addr] = {q.flags.carry, operand[7:1]};
            else
              next_q.work = {q.flags.carry, operand[7:1]};
            next_q.flags.carry = operand[0];
          end
          // carry set means no borrow out of bit 7
          OP_SUBB_W_RAM, OP_SUBB_W_IMM, OP_SUBB_RAM:
          begin
            if (q.cmd.op == OP_SUBB_RAM)
              next_q.ram[q.cmd.addr] = diff[7:0];
            else
              next_q.work = diff[7:0];
            next_q.flags.carry = ~diff[8];
            next_q.flags.half_borrow = ~half_diff[4];
            next_q.flags.null_result = diff[7:0] == BYTE_ZERO;
            next_q.flags.signed_excess = (q.work[7] ^ sub_rhs[7])
              & (q.work[7] ^ diff[7]);
            next_q.flags.signed_borrow = ~((q.work[7] ^ sub_rhs[7])
              & (q.work[7] ^ diff[7]) ^ diff[7]);
            next_q.flags.chained_zero = (diff[7:0] == BYTE_ZERO)
              & q.flags.null_result;
          end
          // decrement never touches the flags
          OP_DEC_SKIP_MEM, OP_DEC_SKIP_W:
          begin
            if (q.cmd.op == OP_DEC_SKIP_MEM)
              next_q.ram[q.cmd.addr] = dec_val;
            else
              next_q.work = dec_val;
            if (dec_val == BYTE_ZERO)
            begin
              // skip the following word, spend a dummy cycle
              next_q.pc = q.pc + 11'h002;
              next_q.skipped = 1'b1;
              next_q.st = S_DUMMY;
              next_q.apb.pready = 1'b0;
            end
          end
          // push return address, then spend a dummy cycle
          OP_PUSH_CALL:
          begin
            next_q.stack[q.sp] = pc_next_seq;
            next_q.sp = sp_inc;
            if (q.depth != 3'(STACK_LEVELS))
              next_q.depth = q.depth + 3'h1;
            next_q.pc = q.cmd.target;
            next_q.st = S_DUMMY;
            next_q.apb.pready = 1'b0;
          end
          default:
          begin
          end
        endcase
      end

      // slot of the skipped or reloaded fetch
      S_DUMMY:
      begin
        next_q.st = S_IDLE;
        next_q.apb.pready = 1'b1;
      end

      S_VECT:
      begin
        // push the resume address, enter service routine
        next_q.stack[q.sp] = q.pc;
        next_q.sp = sp_inc;
        if (q.depth != 3'(STACK_LEVELS))
          next_q.depth = q.depth + 3'h1;
        next_q.pc = IRQ_VECTOR;
        next_q.gie = 1'b0;
        next_q.vect_pulse = 1'b1;
        next_q.st = S_IDLE;
        next_q.apb.pready = 1'b1;
      end
      // unused state code falls back to idle
      default:
      begin
        next_q.st = S_IDLE;
      end
    endcase
  end

  // one register holds all state, ram included
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= next_q;
  end

  // every output comes straight from the state register
  assign prdata = q.apb.prdata;
  assign pready = q.apb.pready;
  assign pslverr = q.apb.pslverr;
  assign global_irq_enable = q.gie;
  assign irq_vector_taken = q.vect_pulse;

endmodule
`default_nettype wire

// ===== lrs_monitor.sv
`default_nettype none
module lrs_monitor
  import lrs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt side
  input wire logic irq_request,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_reply;
    pready ##1 !pready;
  endsequence

  property p_answer;
    s_wait |-> ##[1:4] s_reply;
  endproperty
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  property p_err_qual;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  property p_vec_access;
    irq_vector_taken |-> psel && penable && pwrite && pready;
  endproperty
  property p_vec_cause;
    irq_vector_taken |-> $past(irq_request, 4);
  endproperty
  property p_vec_gie;
    irq_vector_taken |-> ##[0:1] !global_irq_enable;
  endproperty
  property p_vec_pulse;
    irq_vector_taken |=> !irq_vector_taken;
  endproperty
  property p_gie_rise;
    $rose(global_irq_enable) |-> psel && penable && pwrite;
  endproperty

  a_answer: assert property (p_answer)
    else $error("apb answer missing or too long");
  a_in_access: assert property (p_in_access)
    else $error("ready outside access phase");
  a_err_qual: assert property (p_err_qual)
    else $error("error without ready or with data");
  a_vec_access: assert property (p_vec_access)
    else $error("vectoring outside a command");
  a_vec_cause: assert property (p_vec_cause)
    else $error("vectoring without pending request");
  a_vec_gie: assert property (p_vec_gie)
    else $error("vectoring left interrupts enabled");
  a_vec_pulse: assert property (p_vec_pulse)
    else $error("vector pulse too long");
  a_gie_rise: assert property (p_gie_rise)
    else $error("enable rose outside a command");
endmodule

bind lrs_core lrs_monitor mon_u (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq_request(irq_request),
  .global_irq_enable(global_irq_enable),
  .irq_vector_taken(irq_vector_taken)
);
`default_nettype wire

// ===== lrs_tb.sv
`default_nettype none
module testbench
  import lrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic irq_request = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic global_irq_enable;
  logic irq_vector_taken;
  int err_total = 0;
  int total_checks = 0;
  int vect_seen = 0;

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (irq_vector_taken === 1'b1)
      vect_seen <= vect_seen + 1;

  lrs_core dut_u (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_request(irq_request),
    .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; n counts edges from access start to ready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e, output int n);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
      chk(1'b0, 1'b1, "no ready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, a, d, q, e, n);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    int n;
    apb(1'b0, a, 32'h00000000, q, e, n);
  endtask

  function automatic logic [11:0] ram_a(input int i);
    return 12'h200 + 12'(i * 4);
  endfunction

  task automatic model(input int op, input int imm, inout int w,
                       inout int m, inout int st, inout int pc);
    int c, r, s, d, ov, hb, z, sb, sk;
    c = st & 1;
    sk = 0;
    st = st & 'h3F;
    if (op == 0 || op > 20)
      r = 0;
    else if (op <= 3)
    begin
      r = w | ((op == 2) ? imm : m);
      z = (r == 0) ? 1 : 0;
      st = (st & 'h3B) | (z << 2);
      if (op == 3)
        m = r;
      else
        w = r;
    end
    else if (op <= 14)
    begin
      case (op)
        7, 8: r = ((m << 1) | (m >> 7)) & 255;
        9, 10: r = ((m << 1) | c) & 255;
        11, 12: r = (m >> 1) | ((m & 1) << 7);
        default: r = (m >> 1) | (c << 7);
      endcase
      if (op == 9 || op == 10)
        st = (st & 'h3E) | (m >> 7);
      if (op == 13 || op == 14)
        st = (st & 'h3E) | (m & 1);
      if (op % 2 == 1)
        m = r;
      else
        w = r;
    end
    else if (op <= 17)
    begin
      s = (op == 16) ? imm : m;
      d = w - s - (1 - c);
      r = d & 255;
      ov = (((w ^ s) & (w ^ r) & 128) != 0) ? 1 : 0;
      hb = (((w & 15) - (s & 15) - (1 - c)) >= 0) ? 1 : 0;
      z = (r == 0) ? 1 : 0;
      sb = (ov == (r >> 7)) ? 1 : 0;
      st = ((d >= 0) ? 1 : 0) | (hb << 1) | (z << 2) | (ov << 3) | (sb << 4)
           | ((z & (st >> 2) & 1) << 5);
      if (op == 17)
        m = r;
      else
        w = r;
    end
    else
    begin
      r = (m - 1) & 255;
      sk = (r == 0) ? 1 : 0;
      if (op == 18)
        m = r;
      else
        w = r;
    end
    pc = (pc + 1 + sk) & 'h7FF;
    st = st | (sk << 9);
  endtask

  initial
  begin
    #200000;
    err_total++;
    $display("watchdog expired");
    complete_run();
  end

  initial
  begin
    int ops[$];
    int op, a, w, m, imm, st, pc, n, k, pc0, tgt;
    logic [31:0] q;
    logic e;
    ops = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 31};
    void'($urandom(87));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(REG_WORK, q);
    chk(q, 32'h00000000, "work reset");
    rd(REG_STATUS, q);
    chk(q, 32'h00000000, "status reset");
    apb(1'b0, 12'h100, 32'h00000000, q, e, n);
    chk(e, 1'b1, "unmapped read error");
    chk(q, 32'h00000000, "unmapped read data");
    apb(1'b1, REG_STACK_TOP, 32'h00000001, q, e, n);
    chk(e, 1'b1, "stack top write");
    $display("test reset and refusal done");

    for (int i = 0; i < ops.size() * 4; i++)
    begin
      op = ops[i % ops.size()];
      a = $urandom % 128;
      w = $urandom % 256;
      m = ($urandom % 4 == 0) ? 1 : $urandom % 256;
      imm = $urandom % 256;
      st = $urandom % 64;
      pc = $urandom % 2048;
      wr(ram_a(a), m);
      wr(REG_WORK, w);
      wr(REG_STATUS, st);
      wr(REG_COUNTER, pc);
      apb(1'b1, REG_COMMAND, op | (a << 8) | (imm << 16), q, e, n);
      model(op, imm, w, m, st, pc);
      chk(n, 3 + ((st >> 9) & 1), "cycles");
      rd(REG_WORK, q);
      chk(q, w, "work");
      rd(REG_STATUS, q);
      chk(q & 32'h0000027F, st, "status");
      rd(ram_a(a), q);
      chk(q, m, "ram");
      rd(REG_COUNTER, q);
      chk(q, pc, "counter");
    end
    $display("test random operations done");

    pc0 = $urandom % 1024;
    st = $urandom % 64;
    w = $urandom % 256;
    wr(REG_STATUS, st);
    wr(REG_WORK, w);
    wr(REG_COUNTER, pc0);
    for (k = 4; k <= 7; k++)
    begin
      tgt = $urandom % 2048;
      imm = $urandom % 256;
      if (k == 7)
        wr(REG_STATUS, st);
      apb(1'b1, REG_COMMAND, 20 | (tgt << 16), q, e, n);
      chk(n, 4, "call cycles");
      rd(REG_COUNTER, q);
      chk(q, tgt, "call target");
      rd(REG_STACK_TOP, q);
      chk(q, pc0 + 1, "pushed");
      if (k == 7)
      begin
        irq_request <= 1'b1;
        repeat (4) @(posedge ref_clk);
      end
      apb(1'b1, REG_COMMAND, (k == 7 ? 6 : k) | (imm << 16), q, e, n);
      chk(n, (k == 7) ? 4 : 3, "return cycles");
      if (k == 5)
        w = imm;
      rd(REG_WORK, q);
      chk(q, w, "work after return");
      rd(REG_STATUS, q);
      chk(q & 32'h0000007F, st | ((k == 6) ? 64 : 0), "flags");
      chk(global_irq_enable, (k == 6) ? 1 : 0, "enable pin");
      rd(REG_COUNTER, q);
      chk(q, (k == 7) ? IRQ_VECTOR : pc0 + 1, "resume");
      pc0 = pc0 + 1;
    end
    rd(REG_STACK_TOP, q);
    chk(q, pc0, "interrupted address");
    chk(vect_seen, 1, "vector pulses");
    irq_request <= 1'b0;
    $display("test call and returns done");
    complete_run();
  end
endmodule
`default_nettype wire
